/* File: shared/host_cmd_cfg.svh */
// constants of the host serial command and event unit
// assumes one clock (mclk) and a crystal input sampled as a plain level
// Function
// - hold logic reset while supply low, wait 8 crystal periods
// - async reset pin, then wait 8 crystal periods
// - command 0x80 soft reset, registers to defaults
// - set ready flag on reaching active state
// - stand-by keeps ref and oscillator, power-up returns
// - sleep keeps decoder, power-up runs full initialization
// - master tick is mclk divided by K
// - status bit drives interrupt only when masked in
// - writing one clears status bit, zero keeps
// - shape and polarity bits select interrupt pin format
// - interrupt pulse lasts at least one divided tick
// - thermal refresh flag set on each temperature update
// - one-byte commands, all bits most significant first
// - instruction aborts running instruction, not a read
// - sync bytes touch only the serial port
// - writes take three data bytes, reads return four
// - commands accepted during reads, new read ends old
// - serial edges count only while chip select low
// - realign on select toggle, reset, or sync sequence
// - register command 0 W/R index 0, store at 24th clock
// - power-down field: 00 reset, 01 stand-by, 10 sleep
`ifndef HOST_CMD_CFG_SVH
`define HOST_CMD_CFG_SVH

`define CMD_SOFT_RESET 8'h80
`define CMD_POWER_UP 8'hA0
`define CMD_PD_MASK 8'hE7
`define CMD_PD_BASE 8'h80
`define CMD_START_MASK 8'hF7
`define CMD_START_BASE 8'hE0
`define CMD_SYNC_FILL 8'hFF
`define CMD_SYNC_LAST 8'hFE
`define SYNC_FILL_MIN 2'h3
`define PD_SOFT_RESET 2'h0
`define PD_STANDBY 2'h1
`define PD_SLEEP 2'h2

`define IDX_CONFIG 5'h00
`define IDX_STATUS 5'h0F
`define IDX_TEMP 5'h13
`define IDX_MASK 5'h1A

`define CFG_RESET 24'h00_0001
`define CFG_K_MSB 3
`define CFG_K_LSB 0
`define CFG_IRQ_POLARITY 4
`define CFG_IRQ_SHAPE 5
`define ST_READY_BIT 23
`define ST_THERMAL_BIT 7

`define INIT_XTAL_PERIODS 4'h8
`define WRITE_DATA_BYTES 2'h3
`define PULSE_TICKS 2'h2
`define TX_WORD_BITS 32

`endif

/* File: shared/host_cmd_pkg.sv */
// types of the host serial command and event unit
// assumes host_cmd_cfg.svh holds the numeric constants
package host_cmd_pkg;

  typedef enum logic [2:0] {
    pwr_reset_hold,
    pwr_init_wait,
    pwr_active,
    pwr_standby,
    pwr_sleep
  } power_state_t;

  typedef enum logic {
    dec_command,
    dec_write_data
  } decode_state_t;

  typedef struct packed {
    logic ref_osc_on;
    logic core_on;
    logic computing;
  } power_ctl_t;

  typedef struct packed {
    logic start;
    logic continuous;
    logic abort;
  } instr_t;

endpackage

/* File: rtl/serial_shifter.sv */
// serial receive and transmit shifter of the host port
// assumes cs_n, sclk and sdi are synchronous to mclk and sclk is slow
`timescale 1ns/1ps
`include "host_cmd_cfg.svh"

module serial_shifter #(
  parameter int TX_BITS = `TX_WORD_BITS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  // decoder side
  input wire logic realign,
  input wire logic tx_load,
  input wire logic [TX_BITS-1:0] tx_word,
  output logic [7:0] rx_byte,
  output logic rx_valid
);

  logic sclk_prev;
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic [TX_BITS-1:0] tx_shift;
  logic skip_fall;

  wire sclk_rise = sclk & ~sclk_prev & ~cs_n;
  wire sclk_fall = ~sclk & sclk_prev & ~cs_n;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= sclk;
  end

  // ************************************************
  // receive side, msb first
  // ************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_cnt <= 3'h0;
      rx_shift <= 7'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (cs_n || realign)
        bit_cnt <= 3'h0;
      else if (sclk_rise)
      begin
        rx_shift <= {rx_shift[5:0], sdi};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          rx_byte <= {rx_shift, sdi};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // transmit side, msb first
  // ************************************************
  // the falling edge right after the load belongs to the command byte,
  // so it must not advance the word
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_shift <= '0;
      sdo <= 1'b0;
      skip_fall <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_shift <= tx_word;
      sdo <= tx_word[TX_BITS-1];
      skip_fall <= 1'b1;
    end
    else if (sclk_fall)
    begin
      if (skip_fall)
        skip_fall <= 1'b0;
      else
      begin
        sdo <= tx_shift[TX_BITS-2];
        tx_shift <= {tx_shift[TX_BITS-2:0], 1'b0};
      end
    end
  end

endmodule // serial_shifter

/* File: rtl/host_cmd_unit.sv */
// host serial command, power sequencing and event unit
// assumes pins synchronous to mclk; events and temperature come as pulses
`timescale 1ns/1ps
`include "host_cmd_cfg.svh"

module host_cmd_unit
  import host_cmd_pkg::*;
#(
  parameter int REG_COUNT = 32,
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // supply monitor and crystal
  input wire logic supply_ok,
  input wire logic crystal_input,
  // serial port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  // measurement side
  input wire logic [DATA_W-1:0] event_set,
  input wire logic temp_valid,
  input wire logic [DATA_W-1:0] temp_result,
  // control outputs
  output power_ctl_t power_ctl,
  output instr_t instr,
  output logic divided_core_tick,
  output logic irq_pin
);

  // ************************************************
  // declarations
  // ************************************************
  power_state_t pwr_state;
  decode_state_t dec_state;
  logic [DATA_W-1:0] regs [REG_COUNT];
  logic [DATA_W-1:0] status;
  logic [3:0] xtal_cnt;
  logic xtal_prev;
  logic [1:0] ff_count;
  logic [1:0] wcount;
  logic [DATA_W-1:0] wbuf;
  logic [4:0] widx;
  logic tx_load;
  logic [`TX_WORD_BITS-1:0] tx_word;
  logic realign;
  logic [3:0] div_cnt;
  logic irq_prev;
  logic pulse_on;
  logic [1:0] pulse_ticks;
  logic enter_active;
  logic [7:0] rx_byte;
  logic rx_valid;

  // divider count: K of zero divides by sixteen
  function automatic logic [3:0] div_last(input logic [3:0] k);
    div_last = k - 4'h1;
  endfunction

  // ************************************************
  // serial shifter
  // ************************************************
  serial_shifter #(
    .TX_BITS(`TX_WORD_BITS)
  ) u_shifter (
    .mclk(mclk),
    .resetn(resetn),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .realign(realign),
    .tx_load(tx_load),
    .tx_word(tx_word),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  // ************************************************
  // command decode
  // ************************************************
  wire cmd_valid = rx_valid & (dec_state == dec_command);
  wire data_valid = rx_valid & (dec_state == dec_write_data);
  wire is_reg_cmd = ~rx_byte[7] & ~rx_byte[0];
  wire is_write = rx_byte[6];
  wire [4:0] cmd_idx = rx_byte[5:1];
  wire is_sync_fill = rx_byte == `CMD_SYNC_FILL;
  wire is_sync_last = rx_byte == `CMD_SYNC_LAST;
  wire is_power_up = rx_byte == `CMD_POWER_UP;
  wire is_power_down = (rx_byte & `CMD_PD_MASK) == `CMD_PD_BASE;
  wire [1:0] pd_sel = rx_byte[4:3];
  wire is_start = (rx_byte & `CMD_START_MASK) == `CMD_START_BASE;
  wire is_instr = is_power_up | (is_power_down & pd_sel != 2'h3) | is_start;

  wire do_read = cmd_valid & is_reg_cmd & ~is_write;
  wire do_write_cmd = cmd_valid & is_reg_cmd & is_write;
  wire write_done = data_valid & (wcount == `WRITE_DATA_BYTES - 2'h1);
  wire [DATA_W-1:0] write_word = {wbuf[DATA_W-9:0], rx_byte};
  wire soft_reset = cmd_valid & is_power_down & (pd_sel == `PD_SOFT_RESET);
  wire wake_from_sleep = cmd_valid & is_power_up & (pwr_state == pwr_sleep);
  wire reg_clear = soft_reset | wake_from_sleep | ~supply_ok;
  wire [DATA_W-1:0] read_word = (cmd_idx == `IDX_STATUS) ? status : regs[cmd_idx];

  wire [3:0] k_field = regs[`IDX_CONFIG][`CFG_K_MSB:`CFG_K_LSB];
  wire irq_shape = regs[`IDX_CONFIG][`CFG_IRQ_SHAPE];
  wire irq_polarity = regs[`IDX_CONFIG][`CFG_IRQ_POLARITY];
  wire xtal_rise = crystal_input & ~xtal_prev;

  // ************************************************
  // serial framing: write data, reads, sync sequence
  // ************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dec_state <= dec_command;
      wcount <= 2'h0;
      wbuf <= '0;
      widx <= 5'h00;
      ff_count <= 2'h0;
      realign <= 1'b0;
      tx_load <= 1'b0;
      tx_word <= '0;
    end
    else
    begin
      realign <= 1'b0;
      tx_load <= 1'b0;
      if (cs_n)
      begin
        dec_state <= dec_command;
        ff_count <= 2'h0;
      end
      else if (cmd_valid)
      begin
        if (is_sync_fill && ff_count != `SYNC_FILL_MIN)
          ff_count <= ff_count + 2'h1;
        else if (!is_sync_fill)
          ff_count <= 2'h0;
        if (is_sync_last && ff_count == `SYNC_FILL_MIN)
          realign <= 1'b1;
        if (do_write_cmd)
        begin
          dec_state <= dec_write_data;
          widx <= cmd_idx;
          wcount <= 2'h0;
        end
        if (do_read)
        begin
          // a new read simply reloads, ending the old one
          tx_load <= 1'b1;
          tx_word <= {read_word, 8'h00};
        end
      end
      else if (data_valid)
      begin
        wbuf <= write_word;
        wcount <= wcount + 2'h1;
        if (write_done)
          dec_state <= dec_command;
      end
    end
  end

  // ************************************************
  // register file and status
  // ************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs[i] <= (i == `IDX_CONFIG) ? `CFG_RESET : '0;
      status <= '0;
    end
    else if (reg_clear)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs[i] <= (i == `IDX_CONFIG) ? `CFG_RESET : '0;
      status <= '0;
    end
    else
    begin
      if (write_done && widx != `IDX_STATUS)
        regs[widx] <= write_word;
      if (temp_valid)
        regs[`IDX_TEMP] <= temp_result;
      // hardware set wins over a clear in the same cycle
      status <= (status & ~((write_done && widx == `IDX_STATUS) ? write_word : '0))
        | event_set
        | (temp_valid ? (DATA_W'(1) << `ST_THERMAL_BIT) : '0)
        | (enter_active ? (DATA_W'(1) << `ST_READY_BIT) : '0);
    end
  end

  // ************************************************
  // power sequencing
  // ************************************************
  always_comb
  begin
    enter_active = 1'b0;
    if (pwr_state == pwr_init_wait && xtal_rise && xtal_cnt == `INIT_XTAL_PERIODS - 4'h1)
      enter_active = 1'b1;
    if (cmd_valid && is_power_up && pwr_state == pwr_standby)
      enter_active = 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwr_state <= pwr_init_wait;
      xtal_cnt <= 4'h0;
      xtal_prev <= 1'b0;
      power_ctl <= '0;
      instr <= '0;
    end
    else
    begin
      xtal_prev <= crystal_input;
      instr.start <= 1'b0;
      instr.abort <= 1'b0;
      if (cmd_valid && is_instr && supply_ok)
        instr.abort <= 1'b1;
      if (!supply_ok)
      begin
        pwr_state <= pwr_reset_hold;
        xtal_cnt <= 4'h0;
        instr.continuous <= 1'b0;
      end
      else if (reg_clear)
      begin
        pwr_state <= pwr_init_wait;
        xtal_cnt <= 4'h0;
        instr.continuous <= 1'b0;
      end
      else if (enter_active)
        pwr_state <= pwr_active;
      else
      begin
        case (pwr_state)
          pwr_reset_hold:
            pwr_state <= pwr_init_wait;
          pwr_init_wait:
            if (xtal_rise)
              xtal_cnt <= xtal_cnt + 4'h1;
          pwr_active:
            if (cmd_valid && is_power_down && pd_sel == `PD_STANDBY)
              pwr_state <= pwr_standby;
            else if (cmd_valid && is_power_down && pd_sel == `PD_SLEEP)
              pwr_state <= pwr_sleep;
            else if (cmd_valid && is_start)
            begin
              instr.start <= 1'b1;
              instr.continuous <= rx_byte[3];
            end
            else if (cmd_valid && is_instr)
              instr.continuous <= 1'b0;
          default:
            ;
        endcase
        if (cmd_valid && is_power_down)
          instr.continuous <= 1'b0;
      end
      // supply loss blanks the controls at once, not one state later
      if (!supply_ok)
        power_ctl <= '0;
      else
      begin
        power_ctl.ref_osc_on <= pwr_state != pwr_sleep && pwr_state != pwr_reset_hold;
        power_ctl.core_on <= pwr_state == pwr_active;
        power_ctl.computing <= instr.continuous | instr.start;
      end
    end
  end

  // ************************************************
  // divided core tick
  // ************************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_cnt <= 4'h0;
      divided_core_tick <= 1'b0;
    end
    else if (div_cnt == div_last(k_field))
    begin
      div_cnt <= 4'h0;
      divided_core_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 4'h1;
      divided_core_tick <= 1'b0;
    end
  end

  // ************************************************
  // interrupt pin
  // ************************************************
  wire irq_any = |(status & regs[`IDX_MASK]);
  wire irq_assert = irq_shape ? pulse_on : irq_any;

  // two tick edges guarantee one full divided period in between
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_prev <= 1'b0;
      pulse_on <= 1'b0;
      pulse_ticks <= 2'h0;
      irq_pin <= 1'b1;
    end
    else
    begin
      irq_prev <= irq_any;
      if (irq_any && !irq_prev)
      begin
        pulse_on <= 1'b1;
        pulse_ticks <= 2'h0;
      end
      else if (pulse_on && divided_core_tick)
      begin
        pulse_ticks <= pulse_ticks + 2'h1;
        if (pulse_ticks == `PULSE_TICKS - 2'h1)
          pulse_on <= 1'b0;
      end
      irq_pin <= irq_assert ? irq_polarity : ~irq_polarity;
    end
  end

endmodule // host_cmd_unit

/* File: dv/host_cmd_unit_sva.sv */
// port assertions of the host serial command and event unit
// assumes mclk rising edge and active-low asynchronous resetn
`timescale 1ns/1ps

module host_cmd_unit_sva
  import host_cmd_pkg::*;
#(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // inputs
  input wire logic supply_ok,
  input wire logic crystal_input,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [DATA_W-1:0] event_set,
  input wire logic temp_valid,
  input wire logic [DATA_W-1:0] temp_result,
  // outputs
  input wire logic sdo,
  input wire power_ctl_t power_ctl,
  input wire instr_t instr,
  input wire logic divided_core_tick,
  input wire logic irq_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ****************
  // checks
  // ****************
  // reference may run during the init wait, the core may not
  rst_release_a: assert property ($rose(resetn) |->
    (irq_pin && !power_ctl.core_on && !power_ctl.computing && !sdo) [*8])
    else $error("outputs not idle after reset release");
  supply_hold_a: assert property (!supply_ok |=> power_ctl == 3'h0 && instr == 3'h0)
    else $error("logic ran while supply low");
  supply_rise_a: assert property ($rose(supply_ok) |-> power_ctl == 3'h0 ##1 power_ctl == 3'h0)
    else $error("no init wait after supply rise");
  // four samples high, since a load or shift begun before the deselect may still move the output
  cs_quiet_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) && supply_ok
    && $past(supply_ok) |-> $stable(sdo))
    else $error("serial output moved while deselected");
  start_pulse_a: assert property (instr.start |=> !instr.start)
    else $error("start longer than one cycle");
  abort_pulse_a: assert property (instr.abort |=> !instr.abort)
    else $error("abort longer than one cycle");
  core_ref_a: assert property (power_ctl.core_on |-> power_ctl.ref_osc_on)
    else $error("core on without reference");
  compute_core_a: assert property (power_ctl.computing |-> power_ctl.core_on)
    else $error("computing without core");
endmodule // host_cmd_unit_sva

bind host_cmd_unit host_cmd_unit_sva #(.DATA_W(DATA_W)) u_sva (.mclk(mclk), .resetn(resetn),
  .supply_ok(supply_ok), .crystal_input(crystal_input), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
  .event_set(event_set), .temp_valid(temp_valid), .temp_result(temp_result), .sdo(sdo),
  .power_ctl(power_ctl), .instr(instr), .divided_core_tick(divided_core_tick), .irq_pin(irq_pin));

/* File: dv/host_serial_model.sv */
// host side model: shifts one byte per request on the serial port
// assumes requests wait for busy to fall
`timescale 1ns/1ps

module host_serial_model (
  // clock
  input wire logic mclk,
  // bench side
  input wire logic sel,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic busy,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  logic [5:0] cnt;
  logic [7:0] shift;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    busy = 1'b0;
    rx_byte = 8'h00;
  end
  always @(posedge mclk)
  begin
    cs_n <= !sel;
    if (go && !busy)
    begin
      busy <= 1'b1;
      cnt <= 6'h00;
      shift <= tx_byte;
    end
    else if (busy)
    begin
      cnt <= cnt + 6'h01;
      sclk <= cnt[2]; // four low, four high: slower than the port needs
      if (cnt[2:0] == 3'h0)
        sdi <= shift[7 - cnt[5:3]];
      if (cnt[2:0] == 3'h4)
        rx_byte <= {rx_byte[6:0], sdo};
      if (cnt == 6'h3F)
      begin
        busy <= 1'b0;
        sclk <= 1'b0;
        sdi <= !sdi; // released data line must not look held
      end
    end
  end
endmodule // host_serial_model

/* File: dv/host_cmd_unit_tb_top.sv */
// self-checking bench of the host serial command and event unit
// assumes host_serial_model on the pins and a reference register array
`timescale 1ns/1ps
`include "host_cmd_cfg.svh"

module host_cmd_unit_tb_top;
  import host_cmd_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic supply_ok = 1'b1;
  logic crystal_input = 1'b0;
  logic sel = 1'b0;
  logic go = 1'b0;
  logic temp_valid = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [23:0] event_set = 24'h00_0000;
  logic [23:0] temp_result = 24'h00_0000;
  logic cs_n, sclk, sdi, sdo, busy, divided_core_tick, irq_pin;
  logic [7:0] rx_byte;
  power_ctl_t power_ctl;
  instr_t instr;
  logic [23:0] m_reg [32];
  logic [31:0] seed = 32'h0001_0C6D;
  int fail_count = 0, num_checks = 0, cyc = 0, n_abort = 0, n_tick = 0, a, t;

  host_cmd_unit DUT (.mclk(mclk), .resetn(resetn), .supply_ok(supply_ok), .crystal_input(crystal_input),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .event_set(event_set), .temp_valid(temp_valid),
    .temp_result(temp_result), .power_ctl(power_ctl), .instr(instr), .divided_core_tick(divided_core_tick),
    .irq_pin(irq_pin));
  host_serial_model host (.mclk(mclk), .sel(sel), .go(go), .tx_byte(tx_byte), .rx_byte(rx_byte),
    .busy(busy), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  initial
  begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    crystal_input <= ~crystal_input;
    cyc <= cyc + 1;
    n_abort <= n_abort + instr.abort;
    n_tick <= n_tick + divided_core_tick;
    if (cyc == 30000)
    begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end
  // ****************
  // tasks
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic send(input logic [7:0] b);
    tx_byte <= b;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (200)
    begin
      @(posedge mclk);
      if (!busy)
        break;
    end
  endtask
  // the first filler byte may carry a command that runs during the read
  task automatic rd(input logic [4:0] idx, input logic [7:0] fill);
    logic [31:0] d;
    send({2'b00, idx, 1'b0});
    for (int i = 0; i < 4; i++)
    begin
      send(i == 0 ? fill : 8'hFF);
      d = {d[23:0], rx_byte};
    end
    chk(d, {m_reg[idx], 8'h00});
  endtask
  task automatic wr(input logic [4:0] idx, input logic [23:0] d);
    send({2'b01, idx, 1'b0});
    for (int i = 2; i >= 0; i--)
      send(d[i*8 +: 8]);
    m_reg[idx] = (idx == `IDX_STATUS) ? m_reg[idx] & ~d : d;
  endtask
  task automatic m_init();
    foreach (m_reg[i])
      m_reg[i] = 24'h00_0000;
    m_reg[`IDX_CONFIG] = `CFG_RESET;
    m_reg[`IDX_STATUS] = 24'h80_0000;
  endtask
  task automatic ev(input logic [23:0] d);
    event_set <= d;
    @(posedge mclk);
    event_set <= 24'h00_0000;
    m_reg[`IDX_STATUS] |= d;
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    m_init();
    tick(2);
    chk({irq_pin, power_ctl, instr}, 7'h40);
    resetn <= 1'b1;
    tick(40);
    sel <= 1'b1;
    rd(`IDX_STATUS, 8'hFF);
    rd(`IDX_CONFIG, 8'hFF);
    chk(power_ctl, 3'h6);
    wr(`IDX_STATUS, 24'hFF_FFFF);
    wr(`IDX_MASK, 24'h00_00FF);
    for (int m = 0; m < 4; m++)
    begin
      wr(`IDX_CONFIG, {18'h0_0000, m[1:0], 4'h4});
      tick(4);
      chk(irq_pin, !m[0]);
      ev(24'h00_0100);
      tick(3);
      chk(irq_pin, !m[0]);
      ev({16'h0000, seed[7:0] | 8'h01});
      seed = lfsr(seed);
      tick(5);
      chk(irq_pin, m[0]);
      tick(30);
      chk(irq_pin, m[1] ? !m[0] : m[0]);
      rd(`IDX_STATUS, 8'hFF);
      wr(`IDX_STATUS, m_reg[`IDX_STATUS]);
      tick(4);
      chk(irq_pin, !m[0]);
    end
    t = n_tick;
    tick(40);
    chk(n_tick - t, 10);
    temp_result <= seed[23:0];
    temp_valid <= 1'b1;
    m_reg[`IDX_TEMP] = seed[23:0];
    m_reg[`IDX_STATUS] |= 24'h00_0080;
    tick(1);
    temp_valid <= 1'b0;
    rd(`IDX_TEMP, 8'hFF);
    rd(`IDX_STATUS, 8'hFF);
    a = n_abort;
    send(8'hE8);
    repeat (3) send(8'hFF);
    send(8'hFE);
    chk({power_ctl, instr.continuous}, 4'hF);
    chk(n_abort - a, 1);
    rd(`IDX_CONFIG, 8'hA0);
    chk(power_ctl, 3'h6);
    chk(n_abort - a, 2);
    send(8'h88);
    chk(power_ctl, 3'h4);
    send(8'hA0);
    chk(power_ctl, 3'h6);
    send(8'h98);
    chk(power_ctl, 3'h6);
    send(8'h90);
    chk(power_ctl, 3'h0);
    send(8'hA0);
    m_init();
    tick(40);
    rd(`IDX_STATUS, 8'hFF);
    wr(`IDX_MASK, 24'h00_0001);
    send(`CMD_SOFT_RESET);
    m_init();
    tick(40);
    rd(`IDX_MASK, 8'hFF);
    wr(`IDX_MASK, seed[23:0]);
    supply_ok <= 1'b0;
    tick(3);
    supply_ok <= 1'b1;
    m_init();
    tick(10);
    chk(power_ctl, 3'h4);
    tick(30);
    rd(`IDX_STATUS, 8'hFF);
    rd(`IDX_MASK, 8'hFF);
    wr(`IDX_CONFIG, 24'h00_0024);
    sel <= 1'b0;
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    m_init();
    tick(10);
    chk(power_ctl, 3'h4);
    tick(30);
    sel <= 1'b1;
    rd(`IDX_CONFIG, 8'hFF);
    stop_test();
  end
endmodule // host_cmd_unit_tb_top
